// ==== rtl/write_mask_pkg.sv ====
// Shared constants for the masked two-word write port
package write_mask_pkg;
  // Data path and array geometry
  localparam int DATA_WIDTH = 36;
  localparam int ADDR_WIDTH = 4;
  localparam int WORD_COUNT = 32;
  // Organization codes on the organization input
  localparam logic [1:0] ORG_X8 = 2'h0;
  localparam logic [1:0] ORG_X18 = 2'h1;
  localparam logic [1:0] ORG_X36 = 2'h2;
  // Lane field positions: x8 nibbles
  localparam int NIB_LOW_LSB = 0;
  localparam int NIB_HIGH_LSB = 4;
  localparam int NIB_WIDTH = 4;
  // Lane field positions: 9-bit bytes for x18 and x36
  localparam int BYTE0_LSB = 0;
  localparam int BYTE1_LSB = 9;
  localparam int BYTE2_LSB = 18;
  localparam int BYTE3_LSB = 27;
  localparam int BYTE_WIDTH = 9;
  // Burst word offsets within one address
  localparam logic FIRST_WORD = 1'h0;
  localparam logic SECOND_WORD = 1'h1;
  // Reset values
  localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 4'h0;
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 36'h000000000;
  // Burst sequencer states, Gray coded
  typedef enum logic [1:0] {
    BURST_IDLE = 2'h0,
    BURST_SECOND = 2'h1
  } burst_state_t;
endpackage : write_mask_pkg

// ==== rtl/lane_mask_decode.sv ====
// Turns active-low lane selects into a per-bit write mask
`timescale 1ns/100ps
module lane_mask_decode
  import write_mask_pkg::*;
(
  // Organization
  input wire logic [1:0] organization,
  // Lane selects for one burst half, active low
  input wire logic lane0_write_select_n,
  input wire logic lane1_write_select_n,
  input wire logic lane2_write_select_n,
  input wire logic lane3_write_select_n,
  input wire logic low_half_write_select_n,
  input wire logic high_half_write_select_n,
  // One bit per data bit, high means written
  output logic [DATA_WIDTH-1:0] mask
);
  // Each lane selects its own field; unselected fields stay zero
  always_comb begin
    mask = DATA_RESET;
    unique case (organization)
      ORG_X8: begin
        mask[NIB_LOW_LSB +: NIB_WIDTH] = {NIB_WIDTH{~low_half_write_select_n}};
        mask[NIB_HIGH_LSB +: NIB_WIDTH] =
          {NIB_WIDTH{~high_half_write_select_n}};
      end
      ORG_X18: begin
        mask[BYTE0_LSB +: BYTE_WIDTH] = {BYTE_WIDTH{~lane0_write_select_n}};
        mask[BYTE1_LSB +: BYTE_WIDTH] = {BYTE_WIDTH{~lane1_write_select_n}};
      end
      ORG_X36: begin
        // all lanes low gives the full word
        mask[BYTE0_LSB +: BYTE_WIDTH] = {BYTE_WIDTH{~lane0_write_select_n}};
        mask[BYTE1_LSB +: BYTE_WIDTH] = {BYTE_WIDTH{~lane1_write_select_n}};
        mask[BYTE2_LSB +: BYTE_WIDTH] = {BYTE_WIDTH{~lane2_write_select_n}};
        mask[BYTE3_LSB +: BYTE_WIDTH] = {BYTE_WIDTH{~lane3_write_select_n}};
      end
      // Unused code writes nothing rather than guessing a layout
      default: mask = DATA_RESET;
    endcase
  end
endmodule : lane_mask_decode

// ==== rtl/masked_write_port.sv ====
// Two-word-burst write port with per-half lane masking into the array
// Notes on behaviour
// - x18: lane 0 only writes low byte; x8: low half select alone writes low nibble
// - x18: lane 1 only writes high byte; x8: high half select alone writes high nibble
// - x8/x18: both selects high, nothing written
// - x36: all selects low, whole word written
// - x36: lane 0 only writes byte 8:0
// - x36: single upper lane writes its byte
// - x36: all selects high, word untouched
// - Each burst half masked from its own selects
// - Address with first word, then second word
`timescale 1ns/100ps
module masked_write_port
  import write_mask_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Organization of the data bus
  input wire logic [1:0] organization,
  // Write request, active low, with its address
  input wire logic write_port_select_n,
  input wire logic [ADDR_WIDTH-1:0] write_address,
  // Write data, one word per burst half
  input wire logic [DATA_WIDTH-1:0] write_data,
  // Lane selects, active low
  input wire logic lane0_write_select_n,
  input wire logic lane1_write_select_n,
  input wire logic lane2_write_select_n,
  input wire logic lane3_write_select_n,
  input wire logic low_half_write_select_n,
  input wire logic high_half_write_select_n,
  // Observation of the array contents
  input wire logic [ADDR_WIDTH-1:0] peek_address,
  input wire logic peek_word,
  output logic [DATA_WIDTH-1:0] peek_data,
  // High while the second half of a burst is expected
  output logic burst_second_half
);
  // Array: two words per address, indexed by {address, word}.
  // The x8 and x18 organizations leave the upper bits of each word unused.
  logic [DATA_WIDTH-1:0] array_words [WORD_COUNT];

  // Burst sequencer state
  burst_state_t state;
  burst_state_t next_state;

  // Address held from the first half for the second half
  logic [ADDR_WIDTH-1:0] burst_address;
  logic [ADDR_WIDTH-1:0] next_burst_address;

  // Which half of a burst, if any, writes at the coming edge
  logic first_half_write;
  logic second_half_write;

  // Array write strobe
  logic write_enable;

  // Array word indices
  logic [ADDR_WIDTH:0] first_index;
  logic [ADDR_WIDTH:0] second_index;
  logic [ADDR_WIDTH:0] write_index;

  // Lane merge of the coming write
  logic [DATA_WIDTH-1:0] lane_mask;
  logic [DATA_WIDTH-1:0] stored_word;
  logic [DATA_WIDTH-1:0] kept_bits;
  logic [DATA_WIDTH-1:0] new_bits;
  logic [DATA_WIDTH-1:0] merged_word;

  // Observation path
  logic [ADDR_WIDTH:0] peek_index;
  logic [DATA_WIDTH-1:0] next_peek_data;

  // Selects are decoded fresh every cycle, so each half has its own mask.
  // Nothing is latched here: a late select change lands in that half only.
  // per-half mask decode
  lane_mask_decode lane_mask_decode_inst (
    .organization(organization),
    .lane0_write_select_n(lane0_write_select_n),
    .lane1_write_select_n(lane1_write_select_n),
    .lane2_write_select_n(lane2_write_select_n),
    .lane3_write_select_n(lane3_write_select_n),
    .low_half_write_select_n(low_half_write_select_n),
    .high_half_write_select_n(high_half_write_select_n),
    .mask(lane_mask)
  );

  // Half decode. A request is honoured from idle only, so a select held
  // low through the second half cannot start a burst on top of it.
  // The decode is shared by the sequencer and the write port.
  always_comb begin
    first_half_write = 1'h0;
    second_half_write = 1'h0;
    unique case (state)
      BURST_IDLE: begin
        first_half_write = !write_port_select_n;
      end
      BURST_SECOND: begin
        // second word on the following edge
        second_half_write = 1'h1;
      end
    endcase
  end

  // Burst sequencer: one cycle per half, so bursts can follow every two
  // cycles; a new request waits until the second half has been taken.
  // A reset in mid-burst drops the pending second half.
  always_comb begin
    next_state = state;
    unique case (state)
      BURST_IDLE: begin
        if (first_half_write) begin
          next_state = BURST_SECOND;
        end
      end
      BURST_SECOND: begin
        next_state = BURST_IDLE;
      end
    endcase
  end

  // Held address: loaded only with a granted request, so a released bus
  // that wanders in idle cannot steer the second word elsewhere
  always_comb begin
    next_burst_address = burst_address;
    if (first_half_write) begin
      next_burst_address = write_address;
    end
  end

  // Word indices for the two halves of a burst.
  // Both are formed every cycle; only the write strobe picks one.
  // first word with the address, second from the held one
  always_comb begin
    first_index = {write_address, FIRST_WORD};
    second_index = {burst_address, SECOND_WORD};
  end

  // Write target. Writes are held off in reset so that a controller that
  // starts early cannot land a word before the sequencer is known idle.
  // In idle with no request the index rests on the held word; it is read, never written.
  always_comb begin
    write_enable = 1'h0;
    write_index = second_index;
    if (first_half_write) begin
      write_enable = resetn;
      write_index = first_index;
    end else if (second_half_write) begin
      write_enable = resetn;
      write_index = second_index;
    end
  end

  // Lane merge: deselected bits keep the stored value. An all-high select
  // set gives an all-zero mask, so the word is rewritten with itself; this
  // costs a read of the array per write but needs no bit-level enables.
  always_comb begin
    stored_word = array_words[write_index];
    kept_bits = stored_word & ~lane_mask;
    new_bits = write_data & lane_mask;
    merged_word = kept_bits | new_bits;
  end

  // Observation index: word select is the low bit, as for writes.
  // The peek port only reads, so it cannot disturb a burst.
  always_comb begin
    peek_index = {peek_address, peek_word};
    next_peek_data = array_words[peek_index];
  end

  // Sequencer register; reset leaves the port idle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= BURST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Held address register; its reset value is never used for a write
  // because the sequencer always passes through idle first
  always_ff @(posedge clock) begin
    if (!resetn) begin
      burst_address <= ADDR_RESET;
    end else begin
      burst_address <= next_burst_address;
    end
  end

  // Observation register, registered for a clean data output; it reads
  // zero in reset because the array itself is never cleared
  always_ff @(posedge clock) begin
    if (!resetn) begin
      peek_data <= DATA_RESET;
    end else begin
      peek_data <= next_peek_data;
    end
  end

  // Array is not reset: contents survive like a real memory.
  // A peek of the word being written at the same edge still sees the old
  // word; it shows the new one an edge later.
  // masked merge into array
  always_ff @(posedge clock) begin
    if (write_enable) begin
      array_words[write_index] <= merged_word;
    end
  end

  // Second half indicator straight from the state flip-flop
  assign burst_second_half = (state == BURST_SECOND);
endmodule : masked_write_port

// ==== testbench/write_master.sv ====
// Controller model issuing two-word write bursts
`timescale 1ns/100ps
module write_master
  import write_mask_pkg::*;
(
  // Clock in; sel_n is {half1, half0, lane3, lane2, lane1, lane0}
  input wire logic clock,
  output logic write_port_select_n = 1'h1,
  output logic [ADDR_WIDTH-1:0] write_address = 4'h0,
  output logic [DATA_WIDTH-1:0] write_data = 36'h0,
  output logic [5:0] sel_n = 6'h3F
);
  task automatic burst(input logic [3:0] a, input logic [35:0] d,
    input logic [5:0] s0, s1);
    @(posedge clock);
    write_port_select_n <= 1'h0;
    write_address <= a;
    write_data <= d;
    sel_n <= s0;
    @(posedge clock);
    write_port_select_n <= 1'h1;
    write_data <= ~d;
    sel_n <= s1;
    // Released lines flip so a stale word never looks valid
    @(posedge clock);
    write_data <= d;
    write_address <= ~a;
  endtask : burst
endmodule : write_master

// ==== testbench/write_port_sva.sv ====
// Checker for bursts and lane masks of the write port
`timescale 1ns/100ps
module write_port_sva
  import write_mask_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Burst control and data
  input wire logic write_port_select_n,
  input wire logic burst_second_half,
  input wire logic [1:0] organization,
  input wire logic [ADDR_WIDTH-1:0] write_address,
  input wire logic [DATA_WIDTH-1:0] write_data,
  // Observation
  input wire logic [ADDR_WIDTH-1:0] peek_address,
  input wire logic peek_word,
  input wire logic [DATA_WIDTH-1:0] peek_data,
  // Selects, active low
  input wire logic lane0_write_select_n,
  input wire logic lane1_write_select_n,
  input wire logic lane2_write_select_n,
  input wire logic lane3_write_select_n,
  input wire logic low_half_write_select_n,
  input wire logic high_half_write_select_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Peek parked on the target word makes each mask visible
  wire [3:0] ln = {lane3_write_select_n, lane2_write_select_n,
    lane1_write_select_n, lane0_write_select_n};
  wire [4:0] pk = {peek_address, peek_word};
  wire req = !write_port_select_n && !burst_second_half;
  wire hit = req && pk == {write_address, 1'h0};
  wire h36 = hit && organization == ORG_X36;
  second_half_a: assert property (req |=> burst_second_half)
    else $error("no second half");
  one_half_a:
    assert property (burst_second_half |=> !burst_second_half) else $error("held");
  idle_hold_a:
    assert property (write_port_select_n && !burst_second_half
      |=> !burst_second_half) else $error("spurious burst");
  full_word_a:
    assert property (h36 && ln == 4'h0 ##1 $stable(pk)
      |=> peek_data == $past(write_data, 2)) else $error("word lost");
  word_untouched_a:
    assert property (h36 && &ln ##1 $stable(pk) |=> $stable(peek_data))
    else $error("word changed");
  low_byte_a:
    assert property (h36 && ln == 4'hE ##1 $stable(pk) |=> $stable(
      peek_data[35:9]) && peek_data[8:0] == $past(write_data[8:0], 2))
    else $error("low byte wrong");
  nibble_none_a:
    assert property (hit && organization == ORG_X8 && low_half_write_select_n
      && high_half_write_select_n ##1 $stable(pk) |=> $stable(peek_data))
    else $error("x8 word changed");
  second_word_a:
    assert property (burst_second_half && organization == ORG_X36 && ln == 4'h0
      && pk == {$past(write_address), 1'h1} ##1 $stable(pk)
      |=> peek_data == $past(write_data, 2)) else $error("second word lost");
  cover property (req ##1 burst_second_half);
  cover property (h36 && ln == 4'hE);
  cover property (hit && organization == ORG_X8);
endmodule : write_port_sva
bind masked_write_port write_port_sva write_port_sva_inst (
  .clock(clock),
  .resetn(resetn),
  .write_port_select_n(write_port_select_n),
  .burst_second_half(burst_second_half),
  .organization(organization),
  .write_address(write_address),
  .write_data(write_data),
  .peek_address(peek_address),
  .peek_word(peek_word),
  .peek_data(peek_data),
  .lane0_write_select_n(lane0_write_select_n),
  .lane1_write_select_n(lane1_write_select_n),
  .lane2_write_select_n(lane2_write_select_n),
  .lane3_write_select_n(lane3_write_select_n),
  .low_half_write_select_n(low_half_write_select_n),
  .high_half_write_select_n(high_half_write_select_n)
);

// ==== testbench/masked_write_port_tb_top.sv ====
// Self-checking bench for the masked write port
`timescale 1ns/100ps
module masked_write_port_tb_top
  import write_mask_pkg::*;
;
  // Drive, observation and reference
  logic clock = 1'h0, resetn = 1'h0, peek_word = 1'h0;
  logic write_port_select_n, burst_second_half;
  logic [1:0] organization = ORG_X36;
  logic [ADDR_WIDTH-1:0] peek_address = 4'h0, write_address;
  logic [DATA_WIDTH-1:0] write_data, peek_data, ref_mem [WORD_COUNT];
  logic [DATA_WIDTH-1:0] pat = 36'h5A3C96E1F;
  logic [5:0] sel_n;
  int n_fail = 0, check_count = 0;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED at %0t: %h vs %h", $time, g, e); end end
  // 50 ns half period gives 10 MHz
  always #50 clock = ~clock;
  // Controller model and the port under test
  write_master write_master_inst (
    .clock(clock),
    .write_port_select_n(write_port_select_n),
    .write_address(write_address),
    .write_data(write_data),
    .sel_n(sel_n)
  );
  masked_write_port masked_write_port_inst (
    .clock(clock),
    .resetn(resetn),
    .organization(organization),
    .write_port_select_n(write_port_select_n),
    .write_address(write_address),
    .write_data(write_data),
    .lane0_write_select_n(sel_n[0]),
    .lane1_write_select_n(sel_n[1]),
    .lane2_write_select_n(sel_n[2]),
    .lane3_write_select_n(sel_n[3]),
    .low_half_write_select_n(sel_n[4]),
    .high_half_write_select_n(sel_n[5]),
    .peek_address(peek_address),
    .peek_word(peek_word),
    .peek_data(peek_data),
    .burst_second_half(burst_second_half)
  );
  // Bits written by one half; narrow modes leave upper data unused
  function automatic logic [35:0] bits(input logic [5:0] s);
    case (organization)
      ORG_X8: return {28'h0, {4{~s[5]}}, {4{~s[4]}}};
      ORG_X18: return {18'h0, {9{~s[1]}}, {9{~s[0]}}};
      ORG_X36: return {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
      default: return 36'h0;
    endcase
  endfunction : bits
  // One burst with the peek port parked so the checker sees it
  task automatic wr(input logic [3:0] a, input logic w,
    input logic [5:0] s0, s1);
    @(posedge clock);
    peek_address <= a;
    peek_word <= w;
    write_master_inst.burst(a, pat, s0, s1);
    ref_mem[{a, 1'h0}] = ref_mem[{a, 1'h0}] & ~bits(s0) | pat & bits(s0);
    ref_mem[{a, 1'h1}] = ref_mem[{a, 1'h1}] & ~bits(s1) | ~pat & bits(s1);
    pat = {pat[26:0], ~pat[35:27]};
  endtask : wr
  // Read back words 0 to 7, one registered cycle each
  task automatic chk_all(input string name);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      peek_address <= 4'(i / 2);
      peek_word <= i[0];
      @(posedge clock);
      #1 `CHK(peek_data, ref_mem[i])
    end
    $display("%s done", name);
  endtask : chk_all
  task automatic t_fill();
    for (int a = 0; a < 4; a++) wr(4'(a), a[0], 6'h30, 6'h30);
    chk_all("fill");
  endtask : t_fill
  task automatic t_x36();
    wr(4'h0, 1'h0, 6'h3E, 6'h3D);
    wr(4'h1, 1'h0, 6'h3B, 6'h37);
    wr(4'h2, 1'h0, 6'h3F, 6'h30);
    wr(4'h3, 1'h1, 6'h30, 6'h3F);
    chk_all("x36 lanes");
  endtask : t_x36
  task automatic t_narrow();
    @(posedge clock);
    organization <= ORG_X18;
    wr(4'h0, 1'h0, 6'h3E, 6'h3D);
    wr(4'h1, 1'h0, 6'h3F, 6'h3C);
    organization <= ORG_X8;
    wr(4'h2, 1'h0, 6'h2F, 6'h1F);
    wr(4'h3, 1'h0, 6'h3F, 6'h0F);
    // Unused organization code writes nothing, even with lanes selected
    organization <= 2'h3;
    wr(4'h1, 1'h0, 6'h00, 6'h00);
    chk_all("x8 and x18");
  endtask : t_narrow
  task automatic end_of_test();
    $display("%0d checks, %0d mismatches", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // Reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'h1;
    #1 `CHK(burst_second_half, 1'h0)
    t_fill();
    t_x36();
    t_narrow();
    end_of_test();
  end
endmodule : masked_write_port_tb_top
